// ==== rtl/bus_agent_end.sv ====
/*
  Bus agent end: an AXI4-Lite slave whose registers order the init sequence,
  error reports, array accesses and device register reads over the link.
  Assumes the memory unit end shares clk_in.
*/
`timescale 1ns/1ns
`include "errlog_consts.svh"

module bus_agent_end (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic backup_bus_wired_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  errlog_if.agent_end link
);
  import errlog_pkg::*;

  // ========================================================================
  // AXI write channel capture
  logic aw_have_r, w_have_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [1:0] wired_sync_r;
  logic [19:0] strap1_r, strap2_r;
  logic rec_en_r, unlocked_r, busy_r, refused_r, bus_sw_seen_r, mod_sw_seen_r;
  logic [15:0] rdata_r;
  init_seq_e seq_r;

  wire wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  wire wr_map = (aw_addr_r[7:5] == 3'h0) && (aw_addr_r[1:0] == 2'h0);
  wire wr_ctrl = wr_fire && (aw_addr_r == `A_CTRL);
  wire wr_rep = wr_fire && (aw_addr_r == `A_REPORT);
  wire wr_acc = wr_fire && (aw_addr_r == `A_ACCESS) && !link.acc_busy;
  wire wr_rd = wr_fire && (aw_addr_r == `A_REGRD) && !busy_r;
  wire wr_stat = wr_fire && (aw_addr_r == `A_STATUS);
  // Log readback is held off after cold start until an interchange goes out
  wire rd_locked = (w_data_r[4:0] == `OFS_ERR_LOG) && !unlocked_r;
  // Strobes travel with the write data, so judge the captured copy
  wire full_word = (w_strb_r == 4'hF);

  assign s_axi_awready = !aw_have_r;
  assign s_axi_wready = !w_have_r;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_have_r) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_r) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? `RESP_OKAY : `RESP_DECERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Control registers. Partial byte writes are ignored on action registers, except the write-one clears of the status register.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap1_r <= 20'h00000;
      strap2_r <= 20'h00000;
      rec_en_r <= 1'b0;
    end else if (wr_fire && full_word) begin
      if (aw_addr_r == `A_STRAP1) strap1_r <= w_data_r[19:0];
      if (aw_addr_r == `A_STRAP2) strap2_r <= w_data_r[19:0];
      if (aw_addr_r == `A_CTRL) rec_en_r <= w_data_r[1];
    end
  end

  // Init sequence: init pulse, then phase one, then phase two
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seq_r <= SEQ_IDLE;
    end else begin
      unique case (seq_r)
        SEQ_IDLE: seq_r <= (wr_ctrl && full_word && w_data_r[0]) ? SEQ_INIT : SEQ_IDLE;
        SEQ_INIT: seq_r <= SEQ_PH1;
        SEQ_PH1: seq_r <= SEQ_PH2;
        SEQ_PH2: seq_r <= SEQ_IDLE;
      endcase
    end
  end

  // Board strap pin is set off chip, so it passes two flops before use
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wired_sync_r <= 2'h0;
    end else begin
      wired_sync_r <= {wired_sync_r[0], backup_bus_wired_in};
    end
  end

  // Reserved extra flag forced low, boundary check forced on without
  // speed-read, and the spare bus bit only claimed when both buses are wired
  wire [19:0] strap2_safe = (strap2_r & ~(20'h00001 << `SAB_E_BIT)) |
                            ({19'h00000, !strap2_r[`SAB_R_BIT]} << `SAB_C_BIT);
  wire [19:0] strap1_safe = strap1_r &
                            ~({19'h00000, !wired_sync_r[1]} << (`SAB_BB_LSB + 1));

  assign link.init = (seq_r == SEQ_INIT);
  assign link.init_phase_one = (seq_r == SEQ_PH1);
  assign link.init_phase_two = (seq_r == SEQ_PH2);
  assign link.storage_address_bus = (seq_r == SEQ_PH2) ? strap2_safe : strap1_safe;
  assign link.recovery_enable = rec_en_r;

  // ========================================================================
  // Link request pulses and readback
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link.report_valid <= 1'b0;
      link.report_type <= CODE_NO_ERROR;
      link.report_bus <= 3'h0;
      link.report_module <= 6'h00;
      link.acc_req <= 1'b0;
      link.acc_addr <= 20'h00000;
      link.reg_rd <= 1'b0;
      link.reg_addr <= 5'h00;
    end else begin
      link.report_valid <= wr_rep && full_word;
      link.acc_req <= wr_acc && full_word;
      link.reg_rd <= wr_rd && full_word && !rd_locked;
      if (wr_rep) begin
        link.report_type <= err_code_e'(w_data_r[3:0]);
        link.report_bus <= w_data_r[6:4];
        link.report_module <= w_data_r[13:8];
      end
      if (wr_acc) link.acc_addr <= w_data_r[19:0];
      if (wr_rd) link.reg_addr <= w_data_r[4:0];
    end
  end

  // Sticky status: hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      unlocked_r <= 1'b0;
      busy_r <= 1'b0;
      refused_r <= 1'b0;
      bus_sw_seen_r <= 1'b0;
      mod_sw_seen_r <= 1'b0;
      rdata_r <= 16'h0000;
    end else begin
      if (wr_rep && full_word && (w_data_r[3:0] == CODE_INTERCHANGE)) unlocked_r <= 1'b1;
      if (link.reg_ack) begin
        busy_r <= 1'b0;
        rdata_r <= link.reg_rdata;
      end else if (wr_rd && full_word && !rd_locked) begin
        busy_r <= 1'b1;
      end
      refused_r <= (wr_rd && full_word && rd_locked) ||
                   (refused_r && !(wr_stat && w_data_r[1]));
      bus_sw_seen_r <= link.bus_switch || (bus_sw_seen_r && !(wr_stat && w_data_r[2]));
      mod_sw_seen_r <= link.module_switch || (mod_sw_seen_r && !(wr_stat && w_data_r[3]));
    end
  end

  // ========================================================================
  // AXI read channel
  wire [31:0] status_word = {25'h0000000, link.fast_ripple, link.buffer_check_en,
                             unlocked_r, mod_sw_seen_r, bus_sw_seen_r, refused_r, busy_r};
  wire rd_map = (s_axi_araddr[7:5] == 3'h0) && (s_axi_araddr[1:0] == 2'h0);
  wire [31:0] rd_mux = (s_axi_araddr == `A_CTRL) ? {30'h00000000, rec_en_r, 1'b0} :
                       (s_axi_araddr == `A_STRAP1) ? {12'h000, strap1_r} :
                       (s_axi_araddr == `A_STRAP2) ? {12'h000, strap2_r} :
                       (s_axi_araddr == `A_ACCESS) ? {12'h000, link.array_addr} :
                       (s_axi_araddr == `A_STATUS) ? status_word :
                       (s_axi_araddr == `A_RDATA) ? {16'h0000, rdata_r} : 32'h00000000;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_map ? `RESP_OKAY : `RESP_DECERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ==== rtl/errlog_consts.svh ====
/*
  Offsets, field positions, fixed field values and timing counts shared by both ends
  of the error-log link. Assumes inclusion by bare name from rtl/.
*/
`ifndef ERRLOG_CONSTS_SVH
`define ERRLOG_CONSTS_SVH

// ==========================================================================
// Device register offsets (link register port)
`define OFS_ERR_LOG 5'h00
`define OFS_DEV_KIND 5'h01

// ==========================================================================
// Fixed device kind fields (class and version values are arbitrary)
`define DEV_CLASS_CODE 3'h5
`define DEV_ALWAYS_ONE 1'h1
`define DEV_VERSION 2'h1
`define CNT_MAX 2'h3

// ==========================================================================
// Strap bit positions on the storage address bus
`define SAB_TT_LSB 0
`define SAB_S_BIT 2
`define SAB_C_BIT 3
`define SAB_E_BIT 4
`define SAB_R_BIT 5
`define SAB_BB_LSB 15
`define SAB_PP_LSB 17
`define SAB_WIDTH 20

// ==========================================================================
// Row boundary: address bits at and above this one select the row
`define ROW_LSB 10

// ==========================================================================
// Timing
`define CLK_MHZ 20
`define ACCESS_NOMINAL_NS 150
`define ACCESS_NOMINAL_CYC ((`ACCESS_NOMINAL_NS * `CLK_MHZ + 999) / 1000)
`define TRANSIENT_WINDOW_CYC 64

// ==========================================================================
// Controller AXI4-Lite register offsets
`define A_CTRL 8'h00
`define A_STRAP1 8'h04
`define A_STRAP2 8'h08
`define A_REPORT 8'h0C
`define A_ACCESS 8'h10
`define A_REGRD 8'h14
`define A_STATUS 8'h18
`define A_RDATA 8'h1C

`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ==== rtl/errlog_pkg.sv ====
/*
  Types shared by the memory end and the agent end.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package errlog_pkg;

  typedef enum logic [3:0] {
    CODE_TOGGLE = 4'h0,
    CODE_DETACH = 4'h1,
    CODE_ATTACH = 4'h2,
    CODE_INTERCHANGE = 4'h3,
    CODE_TEST_REPORT = 4'h4,
    CODE_CORR_ECC = 4'h5,
    CODE_UNCORR_ECC = 4'h6,
    CODE_BUS_MODULE_LOW = 4'h7,
    CODE_BUS_PARITY = 4'h8,
    CODE_MODULE = 4'h9,
    CODE_NO_ERROR = 4'hA,
    CODE_BUS_MODULE_HIGH = 4'hB,
    CODE_BUS_ARBITRATION = 4'hC,
    CODE_UNSAFE_MODULE = 4'hD,
    CODE_MODULE_LINE_PARITY = 4'hE,
    CODE_BUS_LINE_PARITY = 4'hF
  } err_code_e;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_INIT = 2'b01,
    SEQ_PH1 = 2'b10,
    SEQ_PH2 = 2'b11
  } init_seq_e;

endpackage

// ==== rtl/errlog_if.sv ====
/*
  Link between the memory unit end and the bus agent end.
  Assumes both ends run on the same clock; every signal is single driven.
*/
`timescale 1ns/1ns
`include "errlog_consts.svh"

interface errlog_if;
  import errlog_pkg::*;
  // Agent to memory unit
  logic init;
  logic init_phase_one;
  logic init_phase_two;
  logic [`SAB_WIDTH-1:0] storage_address_bus;
  logic report_valid;
  err_code_e report_type;
  logic [2:0] report_bus;
  logic [5:0] report_module;
  logic recovery_enable;
  logic reg_rd;
  logic [4:0] reg_addr;
  logic acc_req;
  logic [`SAB_WIDTH-1:0] acc_addr;
  // Memory unit to agent
  logic reg_ack;
  logic [15:0] reg_rdata;
  logic retry;
  logic stage;
  logic bus_switch;
  logic module_switch;
  logic buffer_check_en;
  logic fast_ripple;
  logic row_strobe;
  logic acc_busy;
  logic acc_done;
  logic [`SAB_WIDTH-1:0] array_addr;

  modport mem_end(
    input init, init_phase_one, init_phase_two, storage_address_bus, report_valid,
    input report_type, report_bus, report_module, recovery_enable, reg_rd, reg_addr,
    input acc_req, acc_addr,
    output reg_ack, reg_rdata, retry, stage, bus_switch, module_switch, buffer_check_en,
    output fast_ripple, row_strobe, acc_busy, acc_done, array_addr
  );
  modport agent_end(
    output init, init_phase_one, init_phase_two, storage_address_bus, report_valid,
    output report_type, report_bus, report_module, recovery_enable, reg_rd, reg_addr,
    output acc_req, acc_addr,
    input reg_ack, reg_rdata, retry, stage, bus_switch, module_switch, buffer_check_en,
    input fast_ripple, row_strobe, acc_busy, acc_done, array_addr
  );
endinterface

// ==== rtl/mem_unit_end.sv ====
/*
  Memory unit end: error report log, classification and recovery pulses,
  start-up configuration latched from the straps, array address mapping.
  Assumes the agent end drives the link on the same clock, so no synchronisers.
*/
`timescale 1ns/1ns
`include "errlog_consts.svh"

module mem_unit_end #(
  parameter int WINDOW_CYCLES = `TRANSIENT_WINDOW_CYC,
  parameter int NOMINAL_CYCLES = `ACCESS_NOMINAL_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  errlog_if.mem_end link
);
  import errlog_pkg::*;

  // ========================================================================
  // Log and configuration state
  err_code_e log_type_r;
  logic [2:0] log_bus_r;
  logic [5:0] log_module_r;
  logic [1:0] report_counter_r;
  logic perm_r;
  logic [15:0] win_cnt_r;
  logic reopen_r;
  logic extra_flag_r;
  logic speed_read_r;
  logic nominal_time_r;
  logic boundary_check_r;
  logic [1:0] board_kind_code_r;
  logic [1:0] partial_ram_code_r;
  logic [1:0] ram_kind_code_r;

  // ========================================================================
  // Classification of an incoming report
  wire err_code_e rt = link.report_type;
  wire win_active = (win_cnt_r != 16'h0000);
  wire same_as_last = win_active && (rt == log_type_r) &&
                      (link.report_module == log_module_r);
  wire is_unsafe = (rt == CODE_UNSAFE_MODULE);
  wire is_perm = is_unsafe || same_as_last;
  wire is_interchange = (rt == CODE_INTERCHANGE);
  wire bus_kind = (rt == CODE_BUS_LINE_PARITY) || (rt == CODE_BUS_ARBITRATION) ||
                  (rt == CODE_BUS_PARITY);
  wire mod_kind = (rt == CODE_MODULE_LINE_PARITY) || is_unsafe ||
                  (rt == CODE_MODULE) || (rt == CODE_UNCORR_ECC);
  wire combo_kind = (rt == CODE_BUS_MODULE_HIGH) || (rt == CODE_BUS_MODULE_LOW);
  wire spare_bus = board_kind_code_r[1];
  // Combined codes prefer the spare bus; without one the module takes over
  wire want_bus = is_perm && (bus_kind || (combo_kind && spare_bus));
  wire want_mod = is_perm && (mod_kind || (combo_kind && !spare_bus));
  wire do_bus_sw = link.report_valid && want_bus && spare_bus &&
                   link.recovery_enable;
  wire do_mod_sw = link.report_valid && want_mod && link.recovery_enable;
  wire [1:0] cnt_inc = (report_counter_r == `CNT_MAX) ? `CNT_MAX :
                       report_counter_r + 2'h1;
  wire [15:0] win_load = WINDOW_CYCLES[15:0];

  // ========================================================================
  // Error log. The type, bus and module fields are not touched by the init
  // pulse so a crash leaves them readable; only the pin reset clears them.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      log_type_r <= CODE_TOGGLE;
      log_bus_r <= 3'h0;
      log_module_r <= 6'h00;
    end else if (link.report_valid) begin
      log_type_r <= rt;
      log_bus_r <= link.report_bus;
      log_module_r <= link.report_module;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      report_counter_r <= 2'h0;
      perm_r <= 1'b0;
    end else if (link.init || (link.report_valid && is_interchange)) begin
      report_counter_r <= 2'h0;
      perm_r <= 1'b0;
    end else if (link.report_valid) begin
      report_counter_r <= cnt_inc;
      perm_r <= is_perm;
    end
  end

  // Window opens on a transient report and again after every bus switch
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      win_cnt_r <= 16'h0000;
    end else if (link.init) begin
      win_cnt_r <= 16'h0000;
    end else if (link.report_valid && (!is_perm || do_bus_sw)) begin
      win_cnt_r <= win_load;
    end else if (win_active) begin
      win_cnt_r <= win_cnt_r - 16'h0001;
    end
  end

  // ========================================================================
  // Recovery pulses
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link.retry <= 1'b0;
      link.stage <= 1'b0;
      link.bus_switch <= 1'b0;
      link.module_switch <= 1'b0;
      reopen_r <= 1'b0;
    end else begin
      link.retry <= link.report_valid || reopen_r;
      link.stage <= link.report_valid;
      link.bus_switch <= do_bus_sw;
      link.module_switch <= do_mod_sw;
      reopen_r <= do_bus_sw;
    end
  end

  // ========================================================================
  // Configuration straps
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      board_kind_code_r <= 2'h0;
      partial_ram_code_r <= 2'h0;
    end else if (link.init_phase_one) begin
      board_kind_code_r <= link.storage_address_bus[`SAB_BB_LSB +: 2];
      partial_ram_code_r <= link.storage_address_bus[`SAB_PP_LSB +: 2];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      extra_flag_r <= 1'b0;
      speed_read_r <= 1'b0;
      nominal_time_r <= 1'b0;
      boundary_check_r <= 1'b1;
      ram_kind_code_r <= 2'h0;
    end else if (link.init_phase_two) begin
      extra_flag_r <= link.storage_address_bus[`SAB_E_BIT];
      speed_read_r <= link.storage_address_bus[`SAB_R_BIT];
      nominal_time_r <= link.storage_address_bus[`SAB_S_BIT];
      boundary_check_r <= link.storage_address_bus[`SAB_C_BIT];
      ram_kind_code_r <= link.storage_address_bus[`SAB_TT_LSB +: 2];
    end
  end

  assign link.buffer_check_en = board_kind_code_r[0];
  assign link.fast_ripple = speed_read_r;

  // ========================================================================
  // Register read port: one cycle, unmapped offsets read zero
  wire [15:0] log_word = {report_counter_r, perm_r, log_type_r, log_bus_r, log_module_r};
  wire [15:0] kind_word = {`DEV_CLASS_CODE, `DEV_ALWAYS_ONE, `DEV_VERSION, extra_flag_r,
                           speed_read_r, nominal_time_r, boundary_check_r,
                           board_kind_code_r, partial_ram_code_r, ram_kind_code_r};
  wire [15:0] rd_mux = (link.reg_addr == `OFS_ERR_LOG) ? log_word :
                       (link.reg_addr == `OFS_DEV_KIND) ? kind_word : 16'h0000;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      link.reg_ack <= 1'b0;
      link.reg_rdata <= 16'h0000;
    end else begin
      link.reg_ack <= link.reg_rd;
      if (link.reg_rd) begin
        link.reg_rdata <= rd_mux;
      end
    end
  end

  // ========================================================================
  // Array address mapping
  function automatic logic [19:0] layout(input logic [19:0] a, input logic [1:0] kind);
    logic [19:0] o;
    o = a;
    unique case (kind)
      2'b10: o = {a[15], a[14], a[19], a[17], a[13:7], a[18], a[16], a[6:0]};
      2'b01: o = {a[17], a[16], a[19], a[15:8], a[18], a[7:0]};
      2'b00: o = a;
      2'b11: o = a; // Undefined kind passes the address unchanged
    endcase
    return o;
  endfunction

  wire [19:0] pmask = {18'h00000, ~partial_ram_code_r};
  wire [19:0] part_a = (ram_kind_code_r == 2'b01) ? (link.acc_addr ^ (pmask << 14)) :
                       (ram_kind_code_r == 2'b00) ? (link.acc_addr ^ (pmask << 16)) :
                       link.acc_addr;
  wire [19:0] mapped_a = layout(part_a, ram_kind_code_r);
  wire [2:0] acc_len = 3'(NOMINAL_CYCLES) + {2'b00, !nominal_time_r};
  wire acc_start = link.acc_req && !link.acc_busy;
  logic [2:0] acc_cnt_r;
  logic [19:0] last_row_r;
  wire row_change = (mapped_a[19:`ROW_LSB] != last_row_r[19:`ROW_LSB]);

  assign link.acc_busy = (acc_cnt_r != 3'h0);

  // Without boundary checking every access must strobe a row, as plain DRAM
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_cnt_r <= 3'h0;
      last_row_r <= 20'h00000;
      link.array_addr <= 20'h00000;
      link.row_strobe <= 1'b0;
      link.acc_done <= 1'b0;
    end else begin
      link.row_strobe <= acc_start && (!boundary_check_r || row_change);
      link.acc_done <= (acc_cnt_r == 3'h1);
      if (acc_start) begin
        acc_cnt_r <= acc_len;
        last_row_r <= mapped_a;
        link.array_addr <= mapped_a;
      end else if (link.acc_busy) begin
        acc_cnt_r <= acc_cnt_r - 3'h1;
      end
    end
  end
endmodule

// ==== test/link_checker.sv ====
/* Checker on the link between the agent end and the memory unit end.
   Assumes one clock and the asynchronous active-low reset of the bench. */
`timescale 1ns/1ns
`include "errlog_consts.svh"
module link_checker (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic report_valid,
  input wire errlog_pkg::err_code_e report_type,
  input wire logic recovery_enable,
  input wire logic retry,
  input wire logic stage,
  input wire logic bus_switch,
  input wire logic module_switch,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_rdata,
  input wire logic acc_req,
  input wire logic acc_busy,
  input wire logic acc_done
);
  import errlog_pkg::*;
  // ==========================================
  // Link properties
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_report_retry: assert property (report_valid |=> retry && stage)
    else $error("no retry after report");
  a_unsafe_switch: assert property (report_valid && report_type == CODE_UNSAFE_MODULE &&
    recovery_enable |=> module_switch)
    else $error("unsafe report not switched");
  a_bus_retry: assert property (bus_switch |=> retry)
    else $error("no retry after bus switch");
  a_switch_enabled: assert property (bus_switch || module_switch |-> $past(recovery_enable))
    else $error("switch while disabled");
  a_bus_kind: assert property (bus_switch |-> $past(report_type) inside {CODE_BUS_LINE_PARITY,
    CODE_BUS_ARBITRATION, CODE_BUS_PARITY, CODE_BUS_MODULE_HIGH, CODE_BUS_MODULE_LOW})
    else $error("bus switch on wrong code");
  a_dev_kind: assert property (reg_rd && reg_addr == `OFS_DEV_KIND |=>
    reg_rdata[15:10] == {`DEV_CLASS_CODE, `DEV_ALWAYS_ONE, `DEV_VERSION})
    else $error("fixed kind fields wrong");
  a_access_busy: assert property (acc_req && !acc_busy |=> acc_busy [*3])
    else $error("access too short");
  a_access_done: assert property ($fell(acc_busy) |-> acc_done)
    else $error("no done at end of access");
endmodule

// ==== test/tb_memory_module_error_log_config.sv ====
/* Bench joining the agent end to the memory unit end over the link.
   Assumes the agent register map and AXI4-Lite timing of the designer. */
`timescale 1ns/1ns
`include "errlog_consts.svh"
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin num_errors++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module tb_memory_module_error_log_config;
  import errlog_pkg::*;
  logic clk_in = 1'h0, rst_n_in = 1'h0, backup_bus_wired_in = 1'h1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, ta, tw, tb;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
  int num_errors = 0, cmp_count = 0;
  always #25 clk_in = ~clk_in;
  errlog_if lk();
  // Short window keeps repeat reports inside it
  mem_unit_end #(.WINDOW_CYCLES(8)) u_mem_unit_end (.clk_in, .rst_n_in, .link(lk));
  bus_agent_end u_bus_agent_end (.clk_in, .rst_n_in, .backup_bus_wired_in, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link(lk));
  link_checker u_link_checker (.clk_in, .rst_n_in, .report_valid(lk.report_valid),
    .report_type(lk.report_type), .recovery_enable(lk.recovery_enable), .retry(lk.retry),
    .stage(lk.stage), .bus_switch(lk.bus_switch), .module_switch(lk.module_switch),
    .reg_rd(lk.reg_rd), .reg_addr(lk.reg_addr), .reg_rdata(lk.reg_rdata),
    .acc_req(lk.acc_req), .acc_busy(lk.acc_busy), .acc_done(lk.acc_done));
  task automatic final_report();
    $display("Counts: %0d mismatches, %0d comparisons", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic hang();
    num_errors++;
    final_report();
  endtask
  // Handshakes are sampled at the falling edge, where they are settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk_in);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge clk_in);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) break;
    end
    s_axi_bready <= 1'h0;
    if (n == 40) hang();
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clk_in);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(negedge clk_in);
      ta = s_axi_arready;
      tb = s_axi_rvalid;
      rdat = s_axi_rdata;
      rrsp = s_axi_rresp;
      @(posedge clk_in);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tb) break;
    end
    s_axi_rready <= 1'h0;
    if (n == 40) hang();
  endtask
  task automatic lg();
    wr(`A_REGRD, 32'h0);
    rd(`A_RDATA);
  endtask
  task automatic t_config();
    wr(`A_STRAP1, 32'h00058000);
    wr(`A_STRAP2, 32'h0000003D);
    wr(`A_CTRL, 32'h3);
    repeat (4) @(posedge clk_in);
    wr(`A_REGRD, 32'h1);
    rd(`A_RDATA);
    `CHK("kind", {`DEV_CLASS_CODE, `DEV_ALWAYS_ONE, `DEV_VERSION, 10'h1F9}, rdat[15:0])
    rd(`A_STATUS);
    `CHK("modes", 2'h3, rdat[6:5])
    rd(8'h40);
    `CHK("unmapped", `RESP_DECERR, rrsp)
    $display("t_config done");
  endtask
  task automatic t_log();
    lg();
    rd(`A_STATUS);
    `CHK("early read", 1'h1, rdat[1])
    wr(`A_REPORT, 32'h3);
    wr(`A_REPORT, 32'h529);
    wr(`A_REPORT, 32'h529);
    lg();
    `CHK("log", 16'hB285, rdat[15:0])
    rd(`A_STATUS);
    `CHK("module switch", 1'h1, rdat[3])
    wr(`A_REPORT, 32'h30D);
    wr(`A_REPORT, 32'h30D);
    lg();
    `CHK("saturate", 3'h7, rdat[15:13])
    wr(`A_REPORT, 32'h3);
    lg();
    `CHK("interchange", 3'h0, rdat[15:13])
    wr(`A_STATUS, 32'hE);
    wr(`A_REPORT, 32'h70F);
    wr(`A_REPORT, 32'h70F);
    rd(`A_STATUS);
    `CHK("bus switch", 2'h1, rdat[3:2])
    wr(`A_CTRL, 32'h0);
    wr(`A_STATUS, 32'hE);
    wr(`A_REPORT, 32'h209);
    wr(`A_REPORT, 32'h209);
    rd(`A_STATUS);
    `CHK("held off", 2'h0, rdat[3:2])
    $display("t_log done");
  endtask
  task automatic t_access();
    wr(`A_ACCESS, 32'h0C000);
    rd(`A_ACCESS);
    `CHK("array addr", 20'h10000, rdat[19:0])
    $display("t_access done");
  endtask
  // Second init: log fields kept, extended timing and forced boundary check
  task automatic t_reinit();
    int n;
    wr(`A_STRAP2, 32'h00000002);
    wr(`A_CTRL, 32'h3);
    repeat (4) @(posedge clk_in);
    lg();
    `CHK("kept", 16'h1202, rdat[15:0])
    wr(`A_REGRD, 32'h1);
    rd(`A_RDATA);
    `CHK("kind2", 10'h07A, rdat[9:0])
    wr(`A_ACCESS, 32'h00400);
    @(negedge clk_in);
    `CHK("row strobe", 1'h1, lk.row_strobe)
    for (n = 0; n < 9 && lk.acc_busy; n++) @(negedge clk_in);
    `CHK("extended", `ACCESS_NOMINAL_CYC + 1, n)
    $display("t_reinit done");
  endtask
  initial begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'h1;
    t_config();
    t_log();
    t_access();
    t_reinit();
    final_report();
  end
endmodule
